// ==== lpa_pkg.sv ====
// Summary of operation
// - Address byte bit 0 selects direction: one reads, zero writes.
// - Regular address compares seven address bits with the seven strap inputs.
// - Reserved bus addresses match like any other, with no exclusion logic.
// - Broadcast address resets to E0h, enabled; acknowledge E0h and E1h.
// - Sub-addresses reset to E2h, E4h, E8h, disabled; no acknowledge then.
// - Software-reset address 06h is acknowledged only as a write.
// - First byte after an acknowledged write address other than 06h goes to control register.
// - Control bits 3..0 are the pointer; bits 7..5 flag and options.
// - With the flag set, the pointer advances after every data byte.
// - Option 000 keeps the pointer fixed; writes overwrite one register.
// - Option 100 cycles all registers, wrapping 1100 to 0000.
// - Option 101 wraps from 0101 to 0010, the brightness registers.
// - Option 110 wraps from 0111 to 0110, the group registers.
// - Option 111 wraps from 0111 to 0010, brightness plus group.
// - Auto-increment changes only the pointer; flag and options stay.
// - Any start pointer 0..12 counts up, 12 wraps to 0, until mode end.
// - Control byte selecting pointer 13, 14 or 15 is not acknowledged.
// - Thirteen byte registers at pointers 00h to 0Ch.
// - Broadcast answered while primary mode bit 0 set; sub-addresses by bits 3..1.
// - Primary mode bits 7..5 read back the flag and option bits.
package lpa_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned NUM_REGS = 13;
    localparam logic [3:0] PTR_MODE_CONFIG_PRIMARY = 4'h0;
    localparam logic [3:0] PTR_MODE_CONFIG_SECONDARY = 4'h1;
    localparam logic [3:0] PTR_BRIGHT0 = 4'h2;
    localparam logic [3:0] PTR_BRIGHT3 = 4'h5;
    localparam logic [3:0] PTR_GDUTY = 4'h6;
    localparam logic [3:0] PTR_GFREQ = 4'h7;
    localparam logic [3:0] PTR_OUTSEL = 4'h8;
    localparam logic [3:0] PTR_SUBADDRESS_ONE_ENABLE = 4'h9;
    localparam logic [3:0] PTR_SUB2 = 4'hA;
    localparam logic [3:0] PTR_SUB3 = 4'hB;
    localparam logic [3:0] PTR_BCAST = 4'hC;
    localparam logic [3:0] PTR_LAST = 4'hC;

    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int unsigned MODE_CONFIG_PRIMARY_BCAST_EN_BIT = 0;
    localparam int unsigned MODE_CONFIG_PRIMARY_SUBADDRESS_ONE_ENABLE_EN_BIT = 3;
    localparam int unsigned MODE_CONFIG_PRIMARY_SUB2_EN_BIT = 2;
    localparam int unsigned MODE_CONFIG_PRIMARY_SUB3_EN_BIT = 1;
    localparam logic [7:0] MODE_CONFIG_SECONDARY_RO_MASK = 8'hC0;

    // ****************************************
    // Codes and reset values
    // ****************************************
    localparam logic [2:0] OPT_ALL = 3'h4;
    localparam logic [2:0] OPT_BRIGHT = 3'h5;
    localparam logic [2:0] OPT_GROUP = 3'h6;
    localparam logic [2:0] OPT_BOTH = 3'h7;
    localparam logic [7:0] SOFTWARE_RESET_CALL_ADDR = 8'h06;
    localparam logic [7:0] CTRL_RST = 8'h80;
    localparam logic [7:0] MODE_CONFIG_PRIMARY_RST = 8'h91;
    localparam logic [7:0] MODE_CONFIG_SECONDARY_RST = 8'h05;
    localparam logic [7:0] BRIGHT_RST = 8'h00;
    localparam logic [7:0] GDUTY_RST = 8'h00;
    localparam logic [7:0] GFREQ_RST = 8'h00;
    localparam logic [7:0] OUTSEL_RST = 8'h00;
    localparam logic [7:0] SUBADDRESS_ONE_ENABLE_RST = 8'hE2;
    localparam logic [7:0] SUB2_RST = 8'hE4;
    localparam logic [7:0] SUB3_RST = 8'hE8;
    localparam logic [7:0] BCAST_RST = 8'hE0;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [NUM_REGS-1:0][7:0] lpa_regfile_type;

    localparam lpa_regfile_type REGS_RST = {BCAST_RST, SUB3_RST,
        SUB2_RST, SUBADDRESS_ONE_ENABLE_RST, OUTSEL_RST, GFREQ_RST, GDUTY_RST,
        BRIGHT_RST, BRIGHT_RST, BRIGHT_RST, BRIGHT_RST,
        MODE_CONFIG_SECONDARY_RST, MODE_CONFIG_PRIMARY_RST};

    typedef struct packed {
        logic increment_flag;
        logic increment_option_high;
        logic increment_option_low;
        logic unused_zero;
        logic [3:0] pointer;
    } lpa_ctrl_type;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SOFTWARE_RESET_CALL_ACK, ST_CTRL,
        ST_CTRL_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK,
        ST_READ_WAIT, ST_IGNORE
    } lpa_state_type;

    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic bit_val;
        logic toggle;
    } lpa_link_type;

    typedef struct packed {
        lpa_state_type state;
        logic phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] txbyte;
        logic rw;
        logic sda_oe;
        logic sda_o;
        logic [1:0] scl_sync;
        logic scl_prev;
        logic [1:0] sda_sync;
        logic sda_prev;
        logic [1:0] tog_sync;
        logic tog_prev;
        logic [6:0] strap_m;
        logic [6:0] strap_s;
        lpa_ctrl_type ctrl;
        lpa_regfile_type regs;
    } lpa_core_type;

endpackage : lpa_pkg

// ==== lpa_target.sv ====
`timescale 1ns/1ps
module lpa_target
    import lpa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial link
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Address straps
    input wire logic [6:0] addr_strap,
    // Register image for the LED logic
    output lpa_regfile_type reg_image,
    output lpa_ctrl_type ctrl_image
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] lpa_next_ptr(input lpa_ctrl_type c);
        logic [3:0] last;
        logic [3:0] wrap;
        logic [3:0] res;
        last = PTR_LAST;
        wrap = PTR_MODE_CONFIG_PRIMARY;
        case ({c.increment_flag, c.increment_option_high,
               c.increment_option_low})
            OPT_ALL: begin
                last = PTR_LAST;
                wrap = PTR_MODE_CONFIG_PRIMARY;
            end
            OPT_BRIGHT: begin
                last = PTR_BRIGHT3;
                wrap = PTR_BRIGHT0;
            end
            OPT_GROUP: begin
                last = PTR_GFREQ;
                wrap = PTR_GDUTY;
            end
            OPT_BOTH: begin
                last = PTR_GFREQ;
                wrap = PTR_BRIGHT0;
            end
            default: begin
                last = PTR_LAST;
                wrap = PTR_MODE_CONFIG_PRIMARY;
            end
        endcase
        // Only the pointer moves; flag and options untouched
        if (!c.increment_flag) begin
            res = c.pointer;
        end else if (c.pointer == last) begin
            res = wrap;
        end else if (c.pointer == PTR_LAST) begin
            res = PTR_MODE_CONFIG_PRIMARY;
        end else begin
            res = c.pointer + 4'h1;
        end
        return res;
    endfunction : lpa_next_ptr

    function automatic logic lpa_addr_hit(input logic [6:0] a,
                                          input logic [6:0] strap,
                                          input lpa_regfile_type r);
        logic reg_hit;
        logic bc_hit;
        logic sub_hit;
        // Plain compares: reserved values are not screened out
        reg_hit = (a == strap);
        bc_hit = (a == r[PTR_BCAST][7:1])
            && r[PTR_MODE_CONFIG_PRIMARY][MODE_CONFIG_PRIMARY_BCAST_EN_BIT];
        sub_hit = ((a == r[PTR_SUBADDRESS_ONE_ENABLE][7:1])
                   && r[PTR_MODE_CONFIG_PRIMARY][MODE_CONFIG_PRIMARY_SUBADDRESS_ONE_ENABLE_EN_BIT])
            || ((a == r[PTR_SUB2][7:1])
                && r[PTR_MODE_CONFIG_PRIMARY][MODE_CONFIG_PRIMARY_SUB2_EN_BIT])
            || ((a == r[PTR_SUB3][7:1])
                && r[PTR_MODE_CONFIG_PRIMARY][MODE_CONFIG_PRIMARY_SUB3_EN_BIT]);
        return reg_hit || bc_hit || sub_hit;
    endfunction : lpa_addr_hit

    // ****************************************
    // Link domain: samples data on each rising link clock
    // ****************************************
    lpa_link_type lnk_ff;
    lpa_link_type nxt_lnk;

    always_comb begin
        nxt_lnk = lnk_ff;
        nxt_lnk.rst_m = nrst;
        nxt_lnk.rst_s = lnk_ff.rst_m;
        if (!lnk_ff.rst_s) begin
            nxt_lnk.bit_val = 1'b0;
            nxt_lnk.toggle = 1'b0;
        end else begin
            nxt_lnk.bit_val = sda_i;
            nxt_lnk.toggle = ~lnk_ff.toggle;
        end
    end

    always_ff @(posedge scl_clk) begin
        lnk_ff <= nxt_lnk;
    end

    // ****************************************
    // Core domain
    // ****************************************
    lpa_core_type core_ff;
    lpa_core_type nxt_core;

    always_comb begin
        logic bit_in;
        logic bit_evt;
        logic start_c;
        logic stop_c;
        logic scl_fall;
        logic [7:0] byte_in;
        logic [7:0] wdata;
        nxt_core = core_ff;
        nxt_core.sda_o = 1'b0;
        nxt_core.scl_sync = {core_ff.scl_sync[0], scl_clk};
        nxt_core.scl_prev = core_ff.scl_sync[1];
        nxt_core.sda_sync = {core_ff.sda_sync[0], sda_i};
        nxt_core.sda_prev = core_ff.sda_sync[1];
        nxt_core.tog_sync = {core_ff.tog_sync[0], lnk_ff.toggle};
        nxt_core.tog_prev = core_ff.tog_sync[1];
        nxt_core.strap_m = addr_strap;
        nxt_core.strap_s = core_ff.strap_m;
        // Bit value is stable until the next rising link edge
        bit_in = lnk_ff.bit_val;
        bit_evt = core_ff.tog_sync[1] ^ core_ff.tog_prev;
        byte_in = {core_ff.shreg[6:0], bit_in};
        start_c = core_ff.scl_sync[1] && core_ff.scl_prev
            && core_ff.sda_prev && !core_ff.sda_sync[1];
        stop_c = core_ff.scl_sync[1] && core_ff.scl_prev
            && !core_ff.sda_prev && core_ff.sda_sync[1];
        scl_fall = core_ff.scl_prev && !core_ff.scl_sync[1];
        wdata = byte_in;
        if (core_ff.ctrl.pointer == PTR_MODE_CONFIG_PRIMARY) begin
            wdata = {core_ff.regs[PTR_MODE_CONFIG_PRIMARY][7:5], byte_in[4:0]};
        end else if (core_ff.ctrl.pointer == PTR_MODE_CONFIG_SECONDARY) begin
            wdata = byte_in & ~MODE_CONFIG_SECONDARY_RO_MASK;
        end

        unique case (core_ff.state)
            ST_IDLE, ST_IGNORE: begin
            end
            ST_ADDR: begin
                if (bit_evt) begin
                    nxt_core.shreg = byte_in;
                    nxt_core.bitcnt = core_ff.bitcnt + 4'h1;
                    if (core_ff.bitcnt == 4'h7) begin
                        nxt_core.rw = bit_in;
                        nxt_core.phase = 1'b0;
                        if (lpa_addr_hit(byte_in[7:1], core_ff.strap_s,
                                         core_ff.regs)) begin
                            nxt_core.state = ST_ADDR_ACK;
                        end else if (byte_in == SOFTWARE_RESET_CALL_ADDR) begin
                            // Write only: read variant never matches
                            nxt_core.state = ST_SOFTWARE_RESET_CALL_ACK;
                            nxt_core.regs = REGS_RST;
                            nxt_core.ctrl = CTRL_RST;
                        end else begin
                            nxt_core.state = ST_IGNORE;
                        end
                    end
                end
            end
            ST_ADDR_ACK, ST_SOFTWARE_RESET_CALL_ACK, ST_CTRL_ACK, ST_WRITE_ACK: begin
                if (scl_fall) begin
                    if (!core_ff.phase) begin
                        nxt_core.phase = 1'b1;
                        nxt_core.sda_oe = 1'b1;
                    end else begin
                        nxt_core.phase = 1'b0;
                        nxt_core.sda_oe = 1'b0;
                        nxt_core.bitcnt = 4'h0;
                        if (core_ff.state == ST_SOFTWARE_RESET_CALL_ACK) begin
                            nxt_core.state = ST_IGNORE;
                        end else if (core_ff.state != ST_ADDR_ACK) begin
                            nxt_core.state = ST_WRITE;
                        end else if (core_ff.rw) begin
                            nxt_core.txbyte =
                                core_ff.regs[core_ff.ctrl.pointer];
                            nxt_core.sda_oe =
                                !core_ff.regs[core_ff.ctrl.pointer][7];
                            nxt_core.state = ST_READ;
                        end else begin
                            nxt_core.state = ST_CTRL;
                        end
                    end
                end
            end
            ST_CTRL: begin
                if (bit_evt) begin
                    nxt_core.shreg = byte_in;
                    nxt_core.bitcnt = core_ff.bitcnt + 4'h1;
                    if (core_ff.bitcnt == 4'h7) begin
                        nxt_core.phase = 1'b0;
                        if (byte_in[3:0] > PTR_LAST) begin
                            nxt_core.state = ST_IGNORE;
                        end else begin
                            nxt_core.ctrl = byte_in;
                            nxt_core.regs[PTR_MODE_CONFIG_PRIMARY][7:5] =
                                byte_in[7:5];
                            nxt_core.state = ST_CTRL_ACK;
                        end
                    end
                end
            end
            ST_WRITE: begin
                if (bit_evt) begin
                    nxt_core.shreg = byte_in;
                    nxt_core.bitcnt = core_ff.bitcnt + 4'h1;
                    if (core_ff.bitcnt == 4'h7) begin
                        nxt_core.regs[core_ff.ctrl.pointer] =
                            wdata;
                        nxt_core.ctrl.pointer =
                            lpa_next_ptr(core_ff.ctrl);
                        nxt_core.phase = 1'b0;
                        nxt_core.state = ST_WRITE_ACK;
                    end
                end
            end
            ST_READ: begin
                if (scl_fall) begin
                    if (core_ff.bitcnt == 4'h7) begin
                        nxt_core.sda_oe = 1'b0;
                        nxt_core.ctrl.pointer =
                            lpa_next_ptr(core_ff.ctrl);
                        nxt_core.state = ST_READ_ACK;
                    end else begin
                        nxt_core.bitcnt = core_ff.bitcnt + 4'h1;
                        nxt_core.txbyte = {core_ff.txbyte[6:0], 1'b0};
                        nxt_core.sda_oe = !core_ff.txbyte[6];
                    end
                end
            end
            ST_READ_ACK: begin
                if (bit_evt) begin
                    if (!bit_in) begin
                        nxt_core.txbyte =
                            core_ff.regs[core_ff.ctrl.pointer];
                        nxt_core.state = ST_READ_WAIT;
                    end else begin
                        nxt_core.state = ST_IGNORE;
                    end
                end
            end
            ST_READ_WAIT: begin
                if (scl_fall) begin
                    nxt_core.sda_oe = !core_ff.txbyte[7];
                    nxt_core.bitcnt = 4'h0;
                    nxt_core.state = ST_READ;
                end
            end
        endcase

        // Bus conditions override any byte in flight
        if (start_c) begin
            nxt_core.state = ST_ADDR;
            nxt_core.bitcnt = 4'h0;
            nxt_core.phase = 1'b0;
            nxt_core.sda_oe = 1'b0;
        end else if (stop_c) begin
            nxt_core.state = ST_IDLE;
            nxt_core.sda_oe = 1'b0;
        end

        if (!nrst) begin
            nxt_core = '0;
            nxt_core.state = ST_IDLE;
            nxt_core.ctrl = CTRL_RST;
            nxt_core.regs = REGS_RST;
        end
    end

    always_ff @(posedge clk) begin
        core_ff <= nxt_core;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sda_o = core_ff.sda_o;
    assign sda_oe = core_ff.sda_oe;
    assign reg_image = core_ff.regs;
    assign ctrl_image = core_ff.ctrl;

endmodule : lpa_target

// ==== lpa_target_assertions.sv ====
`timescale 1ns/1ps
module lpa_target_assertions
    import lpa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial link
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Straps and register images
    input wire logic [6:0] addr_strap,
    input wire lpa_regfile_type reg_image,
    input wire lpa_ctrl_type ctrl_image
);

    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_reset_values;
        $rose(nrst) |-> reg_image == REGS_RST && ctrl_image == CTRL_RST;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("register image not at reset values");

    property p_quiet_after_reset;
        $rose(nrst) |-> !sda_oe [*4];
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset)
        else $error("data wire driven right after reset");

    property p_mode_config_primary_mirror;
        $stable(ctrl_image[7:5]) |-> reg_image[0][7:5] == ctrl_image[7:5];
    endproperty
    a_mode_config_primary_mirror: assert property (p_mode_config_primary_mirror)
        else $error("mode bits 7..5 differ from control bits");

    property p_ptr_range;
        ctrl_image.pointer <= PTR_LAST;
    endproperty
    a_ptr_range: assert property (p_ptr_range)
        else $error("pointer holds a reserved value");

    property p_mode_config_secondary_reserved;
        (reg_image[1] & MODE_CONFIG_SECONDARY_RO_MASK) == 8'h00;
    endproperty
    a_mode_config_secondary_reserved: assert property (p_mode_config_secondary_reserved)
        else $error("secondary mode reserved bits set");

    // Pointer moves at most once per byte, bytes are far apart
    property p_ptr_once_per_byte;
        $changed(ctrl_image.pointer) |=> $stable(ctrl_image.pointer) [*8];
    endproperty
    a_ptr_once_per_byte: assert property (p_ptr_once_per_byte)
        else $error("pointer stepped twice within one byte");

    property p_ack_in_scl_low;
        $changed(sda_oe) |-> !scl_clk;
    endproperty
    a_ack_in_scl_low: assert property (p_ack_in_scl_low)
        else $error("data wire changed while serial clock high");

    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data wire driven high");

    // ****************************************
    // Coverage
    // ****************************************
    c_ack: cover property ($rose(sda_oe));
    c_wrap: cover property ($past(ctrl_image.pointer) == 4'hC
        && ctrl_image.pointer == 4'h0);
    c_store: cover property ($changed(reg_image[2]));

endmodule : lpa_target_assertions

bind lpa_target lpa_target_assertions chk_u (
    .clk(clk),
    .nrst(nrst),
    .scl_clk(scl_clk),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .addr_strap(addr_strap),
    .reg_image(reg_image),
    .ctrl_image(ctrl_image)
);

// ==== lpa_master_model.sv ====
`timescale 1ns/1ps
module lpa_master_model (
    // Serial clock
    output logic scl_clk,
    // Data wire
    output logic sda_low,
    input wire logic sda_line
);

    // ****************************************
    // Bus controller
    // ****************************************
    // Phases kept well above six core cycles for the synchronisers
    localparam int T_Q = 64;

    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end

    // Hold after the fall so a data change never looks like START/STOP
    task automatic fall();
        scl_clk = 1'b0;
        #(T_Q / 4);
    endtask : fall

    task automatic idle_clocks(input int n);
        repeat (n) begin
            scl_clk = 1'b0;
            #(T_Q);
            scl_clk = 1'b1;
            #(T_Q);
        end
    endtask : idle_clocks

    task automatic start_cond();
        sda_low = 1'b0;
        #(T_Q);
        scl_clk = 1'b1;
        #(T_Q);
        sda_low = 1'b1;
        #(T_Q);
        fall();
    endtask : start_cond

    task automatic stop_cond();
        sda_low = 1'b1;
        #(T_Q);
        scl_clk = 1'b1;
        #(T_Q);
        sda_low = 1'b0;
        #(T_Q);
    endtask : stop_cond

    task automatic put_bit(input logic b, output logic seen);
        sda_low = ~b;
        #(T_Q);
        scl_clk = 1'b1;
        #(T_Q);
        seen = sda_line;
        fall();
    endtask : put_bit

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, ack);
    endtask : put_byte

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(last, s);
    endtask : get_byte

endmodule : lpa_master_model

// ==== lpa_target_test.sv ====
`timescale 1ns/1ps
module lpa_target_test
    import lpa_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [6:0] STRAP = 7'h15;
    logic clk, nrst, scl_clk, mst_low, sda_line, sda_o, sda_oe;
    logic [6:0] addr_strap;
    lpa_regfile_type reg_image, exp_regs;
    lpa_ctrl_type ctrl_image, exp_ctrl;
    int n_mismatch, tests_run;
    logic [8:0] probes [12] = '{9'h12A, 9'h12B, 9'h1E0, 9'h1E1, 9'h0E2,
        9'h0E3, 9'h0E4, 9'h0E5, 9'h0E8, 9'h0E9, 9'h007, 9'h054};

    // Pull-up on the wire: released means high
    assign sda_line = ~(mst_low | (sda_oe & ~sda_o));

    lpa_target dut_u (.clk(clk), .nrst(nrst), .scl_clk(scl_clk),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .addr_strap(addr_strap), .reg_image(reg_image),
        .ctrl_image(ctrl_image));
    lpa_master_model mst_u (.scl_clk(scl_clk), .sda_low(mst_low),
        .sda_line(sda_line));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : check

    function automatic logic [3:0] step(input lpa_ctrl_type c);
        if (!c.increment_flag) return c.pointer;
        case ({c.increment_option_high, c.increment_option_low})
            2'b01: if (c.pointer == 4'h5) return 4'h2;
            2'b10: if (c.pointer == 4'h7) return 4'h6;
            2'b11: if (c.pointer == 4'h7) return 4'h2;
            default: ;
        endcase
        return (c.pointer == 4'hC) ? 4'h0 : c.pointer + 4'h1;
    endfunction : step

    function automatic lpa_regfile_type img();
        lpa_regfile_type e;
        e = exp_regs;
        e[0][7:5] = exp_ctrl[7:5];
        e[1] = e[1] & ~MODE_CONFIG_SECONDARY_RO_MASK;
        return e;
    endfunction : img

    task automatic compare_image();
        repeat (4) @(posedge clk);
        #1;
        check(reg_image === img(), "register image");
        check(ctrl_image === exp_ctrl, "control register");
    endtask : compare_image

    task automatic read_one(input logic last);
        logic [7:0] d;
        lpa_regfile_type e;
        e = img();
        mst_u.get_byte(last, d);
        check(d === e[exp_ctrl.pointer], "read data");
        exp_ctrl.pointer = step(exp_ctrl);
    endtask : read_one

    task automatic probe(input logic [7:0] adr, input logic hit);
        logic ack;
        mst_u.start_cond();
        mst_u.put_byte(adr, ack);
        check(ack === ~hit, "address answer");
        if (!ack && adr[0]) begin
            read_one(1'b1);
        end
        mst_u.stop_cond();
    endtask : probe

    task automatic write_burst(input logic [7:0] adr, input logic [7:0] ctl,
            input int n, input logic [7:0] base);
        logic ack;
        logic [7:0] d;
        mst_u.start_cond();
        mst_u.put_byte(adr, ack);
        check(ack === 1'b0, "write address refused");
        mst_u.put_byte(ctl, ack);
        check(ack === 1'b0, "control byte refused");
        exp_ctrl = ctl;
        for (int i = 0; i < n; i++) begin
            d = base + 8'(i) * 8'h11;
            mst_u.put_byte(d, ack);
            check(ack === 1'b0, "data byte refused");
            exp_regs[exp_ctrl.pointer] = d;
            exp_ctrl.pointer = step(exp_ctrl);
        end
        mst_u.stop_cond();
        compare_image();
    endtask : write_burst

    task automatic read_burst(input logic [7:0] ctl, input int n);
        logic ack;
        mst_u.start_cond();
        mst_u.put_byte({STRAP, 1'b0}, ack);
        mst_u.put_byte(ctl, ack);
        check(ack === 1'b0, "control byte refused");
        exp_ctrl = ctl;
        mst_u.start_cond();
        mst_u.put_byte({STRAP, 1'b1}, ack);
        check(ack === 1'b0, "read address refused");
        for (int i = 0; i < n; i++) begin
            read_one(i == n - 1);
        end
        mst_u.stop_cond();
        compare_image();
    endtask : read_burst

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic ack;
        nrst = 1'b0;
        addr_strap = STRAP;
        // Link sampler resets on serial clock edges too
        fork
            repeat (10) @(posedge clk);
            mst_u.idle_clocks(2);
        join
        @(posedge clk);
        #1 nrst = 1'b1;
        exp_regs = REGS_RST;
        exp_ctrl = CTRL_RST;
        compare_image();
        // Link sampler leaves reset only two serial clock rises later
        mst_u.idle_clocks(2);
        foreach (probes[i]) probe(probes[i][7:0], probes[i][8]);
        write_burst({STRAP, 1'b0}, 8'h8B, 4, 8'hED);
        write_burst(8'hEC, 8'hA2, 5, 8'h10);
        probe(8'hE2, 1'b1);
        probe(8'hE0, 1'b0);
        write_burst(8'hFE, 8'hC7, 3, 8'h40);
        write_burst({STRAP, 1'b0}, 8'hE7, 2, 8'h50);
        write_burst({STRAP, 1'b0}, 8'h01, 3, 8'h60);
        mst_u.start_cond();
        mst_u.put_byte({STRAP, 1'b0}, ack);
        mst_u.put_byte(8'h8D, ack);
        check(ack === 1'b1, "reserved pointer taken");
        mst_u.stop_cond();
        compare_image();
        read_burst(8'hA4, 3);
        read_burst(8'hEB, 4);
        probe(8'h06, 1'b1);
        exp_regs = REGS_RST;
        exp_ctrl = CTRL_RST;
        compare_image();
        @(posedge clk);
        #1 addr_strap = 7'h7C;
        repeat (4) @(posedge clk);
        probe(8'hF8, 1'b1);
        probe({STRAP, 1'b0}, 1'b0);
        print_verdict();
    end

    initial begin
        #500000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end

endmodule : lpa_target_test
